// [lss_core.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - Input bit sampled on serial clock rise
// - Output bit changes only on clock fall
// - Chip select fall shows status bit seven
// - Eight-stage shift path for daisy chaining
// - Serial output released while chip select high
// - Clock and input ignored while deselected
// - Chip select rise loads command register
// - Chip select rise clears latched faults
// - Persisting faults relatch after qualification time
// - Overvoltage forces every output off
// - Wake or power-up starts forty microsecond timer
// - Timer running: inputs ignored, outputs off
// - Enable fall outside sleep skips dead time
// - Enable high with sleep bit enters sleep
// - Sleep zeroes registers, clears faults, no detection
// - Dual mode: parallel input drives whole group
// - Dual mode: serial needs all three bits
// - Dual mode only after qualified mid level
// - One eight-bit command word per frame
// - Mid level held over ten microseconds
// - Hex mode: 0-2 ORed, 3-5 serial only
// - Current limit fault: off, refresh, retry
module lss_core #(
   parameter int REFRESH_CYC = lss_pkg::TREF_CYC // Refresh off time
) (
   input  wire logic       clk_in,          // Internal timer clock
   input  wire logic       reset_in,        // Sync reset, power-up
   input  wire logic       sclk_in,         // Serial link clock
   input  wire logic       cs_n_in,         // Chip select, low active
   input  wire logic       si_in,           // Serial data in
   output logic            so_out,          // Serial data out
   output logic            so_oe_out,       // Serial out enable
   input  wire logic       en_n_in,         // Enable, low active
   input  wire logic       par_in_0,        // Parallel input 0
   input  wire logic       par_in_1,        // Parallel input 1
   input  wire logic       par_in_mode_sel, // Parallel input 2 level
   input  wire logic       mode_mid_in,     // Mode pin at mid level
   input  wire logic       supply_sense_in, // Supply above threshold
   input  wire logic [5:0] cur_limit_in,    // Output in current limit
   input  wire logic [5:0] open_load_in,    // Off output reads open
   output logic            drive_out_0,     // Output 0 gate
   output logic            drive_out_1,     // Output 1 gate
   output logic            drive_out_2,     // Output 2 gate
   output logic            drive_out_3,     // Output 3 gate
   output logic            drive_out_4,     // Output 4 gate
   output logic            drive_out_5,     // Output 5 gate
   output logic            dual_mode_out,   // Dual mode selected
   output logic            sleep_out        // Device asleep
);

   localparam int N = lss_pkg::NUM_OUT;
   localparam int PU_W = $clog2(lss_pkg::PU_CYC + 1);
   localparam int MODE_W = $clog2(lss_pkg::MODE_CYC + 1);
   localparam int TSS_W = $clog2(lss_pkg::TSS_CYC + 1);
   localparam int REF_W = $clog2(REFRESH_CYC + 1);

   // True when every command bit of a group is set
   function automatic logic group_on(input logic [5:0] cmd_bits,
                                     input logic [5:0] mask);
      group_on = &(cmd_bits | ~mask);
   endfunction

   lss_pkg::power_state_e state;            // Power state
   logic [lss_pkg::PIN_BITS-1:0] pin_meta;   // Synchroniser stage 1
   logic [lss_pkg::PIN_BITS-1:0] pin_sync;   // Synchroniser stage 2
   logic                 cs_s;               // Synced chip select
   logic                 en_s;               // Synced enable
   logic                 par0_s;             // Synced parallel 0
   logic                 par1_s;             // Synced parallel 1
   logic                 par2_s;             // Synced parallel 2
   logic                 mid_s;              // Synced mid level
   logic                 ov_s;               // Synced overvoltage
   logic [5:0]           curlim_s;           // Synced current limit
   logic [5:0]           open_s;             // Synced open load
   logic                 cs_prev;            // Chip select last cycle
   logic                 cs_rise;            // End of a frame
   logic [PU_W-1:0]      pu_cnt;             // Power-up timer
   logic [MODE_W-1:0]    mode_cnt;           // Mid level persistence
   logic                 dual_mode;          // Dual mode selected
   logic [7:0]           cmd;                // Active command word
   logic [7:0]           status_word;        // Outgoing status word
   logic [5:0]           fault;              // Latched fault flags
   logic [5:0]           fault_set;          // Fault qualifies now
   logic [5:0]           fault_cond;         // Raw fault per output
   logic [TSS_W-1:0]     qual_cnt [N];       // Fault qualification
   logic [REF_W-1:0]     ref_cnt [N];        // Refresh off timer
   logic [5:0]           refresh_off;        // Output held in refresh
   logic [5:0]           want;               // Requested outputs
   logic [5:0]           next_drive;         // Gated outputs
   logic [5:0]           drive;              // Output flops
   logic                 sleep_q;            // Sleep indication flop
   logic                 link_clear;         // Clears link registers
   logic [7:0]           sreg;               // Link shift register
   logic                 rise_seen;          // Clock rose this frame
   logic                 fall_seen;          // Clock fell this frame
   logic                 so_q;               // Bit shifted out

   // ---------------- Link clock domain ----------------

   // Shift register: first rise loads status under the input bit
   always_ff @(posedge sclk_in or posedge link_clear) begin
      if (link_clear) begin
         sreg <= lss_pkg::CMD_RESET;
      end else if (!cs_n_in) begin
         if (rise_seen) begin
            sreg <= {sreg[6:0], si_in};
         end else begin
            sreg <= {status_word[6:0], si_in};
         end
      end
   end

   // Marks the first rising clock edge of a frame
   always_ff @(posedge sclk_in or posedge cs_n_in) begin
      if (cs_n_in) begin
         rise_seen <= 1'b0;
      end else begin
         rise_seen <= 1'b1;
      end
   end

   // Output bit moves on falling edges only
   always_ff @(negedge sclk_in or posedge cs_n_in) begin
      if (cs_n_in) begin
         fall_seen <= 1'b0;
         so_q      <= 1'b0;
      end else begin
         fall_seen <= 1'b1;
         so_q      <= sreg[7];
      end
   end

   // Before the first fall the status MSB stands on the pin
   assign so_out    = fall_seen ? so_q : status_word[7];
   assign so_oe_out = ~cs_n_in;

   // ---------------- Internal clock domain ----------------

   // Two-flop synchroniser for every pin but reset, the link clock and serial data in
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         pin_meta <= lss_pkg::PIN_IDLE;
         pin_sync <= lss_pkg::PIN_IDLE;
      end else begin
         pin_meta <= {cs_n_in, en_n_in, par_in_0, par_in_1,
                      par_in_mode_sel, mode_mid_in, supply_sense_in,
                      cur_limit_in, open_load_in};
         pin_sync <= pin_meta;
      end
   end

   // Named views of the synchronised pins
   assign {cs_s, en_s, par0_s, par1_s, par2_s, mid_s, ov_s,
           curlim_s, open_s} = pin_sync;

   // Frame end detector
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         cs_prev <= 1'b1;
      end else begin
         cs_prev <= cs_s;
      end
   end
   assign cs_rise = cs_s & ~cs_prev;

   // Power state machine with power-up timer
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         state  <= lss_pkg::st_powerup;
         pu_cnt <= '0;
      end else begin
         case (state)
            lss_pkg::st_powerup: begin
               if (pu_cnt == PU_W'(lss_pkg::PU_CYC - 1)) begin
                  state  <= lss_pkg::st_run;
                  pu_cnt <= '0;
               end else begin
                  pu_cnt <= pu_cnt + 1'b1;
               end
            end
            lss_pkg::st_run: begin
               // Enable falling here keeps running
               if (en_s && cmd[lss_pkg::SLEEP_BIT]) begin
                  state <= lss_pkg::st_sleep;
               end
            end
            lss_pkg::st_sleep: begin
               if (!en_s) begin
                  state  <= lss_pkg::st_powerup;
                  pu_cnt <= '0;
               end
            end
            default: begin
               state <= lss_pkg::st_powerup;
            end
         endcase
      end
   end

   // Sleep indication and link register clear
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         sleep_q    <= 1'b0;
         link_clear <= 1'b1;
      end else begin
         sleep_q    <= (state == lss_pkg::st_sleep);
         link_clear <= (state == lss_pkg::st_sleep);
      end
   end

   // Mode qualification on the mid level indication
   always_ff @(posedge clk_in) begin
      if (reset_in || !mid_s) begin
         mode_cnt  <= '0;
         dual_mode <= 1'b0;
      end else if (mode_cnt == MODE_W'(lss_pkg::MODE_CYC - 1)) begin
         dual_mode <= 1'b1;
      end else begin
         mode_cnt <= mode_cnt + 1'b1;
      end
   end

   // Command register loaded at frame end while running
   always_ff @(posedge clk_in) begin
      if (reset_in || state == lss_pkg::st_sleep) begin
         cmd <= lss_pkg::CMD_RESET;
      end else if (cs_rise && state == lss_pkg::st_run) begin
         cmd <= sreg;
      end
   end

   // Raw fault per output and qualification strobe
   always_comb begin
      for (int i = 0; i < N; i++) begin
         fault_cond[i]  = want[i] ? curlim_s[i] : open_s[i];
         refresh_off[i] = (ref_cnt[i] != '0);
         fault_set[i]   = !refresh_off[i] && fault_cond[i] &&
                          state == lss_pkg::st_run &&
                          qual_cnt[i] == TSS_W'(lss_pkg::TSS_CYC - 1);
      end
   end

   // Qualification and refresh timers per output
   always_ff @(posedge clk_in) begin
      for (int i = 0; i < N; i++) begin
         if (reset_in || state == lss_pkg::st_sleep) begin
            qual_cnt[i] <= '0;
            ref_cnt[i]  <= '0;
         end else if (refresh_off[i]) begin
            ref_cnt[i]  <= ref_cnt[i] - 1'b1;
            qual_cnt[i] <= '0;
         end else if (fault_set[i]) begin
            qual_cnt[i] <= '0;
            if (want[i]) begin
               ref_cnt[i] <= REF_W'(REFRESH_CYC);
            end
         end else if (fault_cond[i] && state == lss_pkg::st_run) begin
            qual_cnt[i] <= qual_cnt[i] + 1'b1;
         end else begin
            qual_cnt[i] <= '0;
         end
      end
   end

   // Fault latch: a new fault wins over the frame-end clear
   always_ff @(posedge clk_in) begin
      if (reset_in || state == lss_pkg::st_sleep) begin
         fault <= '0;
      end else begin
         fault <= fault_set | (fault & ~{N{cs_rise}});
      end
   end

   // Status snapshot, frozen while a frame is open
   always_ff @(posedge clk_in) begin
      if (reset_in || state == lss_pkg::st_sleep) begin
         status_word <= lss_pkg::STATUS_RESET;
      end else if (cs_s) begin
         status_word <= {2'b00, fault};
      end
   end

   // Output request mapping for hex and dual mode
   always_comb begin
      logic g0;
      logic g1;
      g0 = par0_s | group_on(cmd[5:0], lss_pkg::GROUP0_MASK);
      g1 = par1_s | group_on(cmd[5:0], lss_pkg::GROUP1_MASK);
      if (dual_mode) begin
         want = ({N{g0}} & lss_pkg::GROUP0_MASK) |
                ({N{g1}} & lss_pkg::GROUP1_MASK);
      end else begin
         want = {cmd[5:3], par2_s | cmd[2], par1_s | cmd[1],
                 par0_s | cmd[0]};
      end
      if (state == lss_pkg::st_run && !ov_s) begin
         next_drive = want & ~refresh_off;
      end else begin
         next_drive = lss_pkg::DRIVE_RESET;
      end
   end

   // Output flops
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         drive <= lss_pkg::DRIVE_RESET;
      end else begin
         drive <= next_drive;
      end
   end

   assign {drive_out_5, drive_out_4, drive_out_3,
           drive_out_2, drive_out_1, drive_out_0} = drive;
   assign dual_mode_out = dual_mode;
   assign sleep_out     = sleep_q;

   // ---------------- Checks ----------------

   logic [PU_W:0] pu_len; // Length of the current power-up stretch

   // Counts consecutive power-up cycles
   always_ff @(posedge clk_in) begin
      if (reset_in || state != lss_pkg::st_powerup) begin
         pu_len <= '0;
      end else begin
         pu_len <= pu_len + 1'b1;
      end
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);

   cmd_load_a: assert property (
      cs_rise && state == lss_pkg::st_run && !(en_s && cmd[7])
      |=> cmd == $past(sreg))
      else $error("command not loaded at frame end");

   fault_clear_a: assert property (
      cs_rise && fault_set == '0 && state == lss_pkg::st_run
      |=> fault == '0)
      else $error("faults not cleared at frame end");

   fault_relatch_a: assert property (
      fault_set[0] && !(en_s && cmd[7])
      |=> fault[0] ##1 (status_word[0] || !$past(cs_s)))
      else $error("fault not latched");

   ov_off_a: assert property (
      ov_s |=> drive == '0)
      else $error("output on during overvoltage");

   powerup_len_a: assert property (
      state == lss_pkg::st_run && $past(state) == lss_pkg::st_powerup
      |-> $past(pu_len) == (PU_W+1)'(lss_pkg::PU_CYC - 1))
      else $error("power-up dead time wrong length");

   powerup_off_a: assert property (
      state == lss_pkg::st_powerup |=> drive == '0 && cmd == $past(cmd))
      else $error("output on in dead time");

   skip_dead_a: assert property (
      state == lss_pkg::st_run && $fell(en_s) |=> state == lss_pkg::st_run)
      else $error("dead time after enable outside sleep");

   sleep_entry_a: assert property (
      state == lss_pkg::st_run && en_s && cmd[7]
      |=> state == lss_pkg::st_sleep ##1 sleep_q)
      else $error("sleep not entered");

   sleep_clear_a: assert property (
      state == lss_pkg::st_sleep |=> cmd == '0 && fault == '0 && drive == '0)
      else $error("registers not cleared in sleep");

   dual_group_a: assert property (
      dual_mode && state == lss_pkg::st_run && !ov_s && refresh_off == '0
      |=> drive[0] == $past(par0_s | (cmd[0] & cmd[4] & cmd[5]))
          && drive[4] == drive[0]
          && drive[5] == drive[0])
      else $error("dual group 0 mismatch");

   hex_map_a: assert property (
      !dual_mode && state == lss_pkg::st_run && !ov_s && refresh_off == '0
      |=> drive[0] == $past(par0_s | cmd[0]) && drive[3] == $past(cmd[3]))
      else $error("hex mapping wrong");

   mode_qual_a: assert property (
      $rose(dual_mode) |-> $past(mid_s, 1) && $past(mid_s, 8))
      else $error("dual mode without held mid level");

   refresh_a: assert property (
      fault_set[0] && want[0] |=> ##1 !drive[0] [*8])
      else $error("output not off during refresh");

   dual_seen_c: cover property ($rose(dual_mode));
   sleep_seen_c: cover property ($rose(state == lss_pkg::st_sleep));
   fault_seen_c: cover property (fault_set != '0);
   frame_load_c: cover property (cs_rise && state == lss_pkg::st_run);

endmodule // lss_core

// [lss_pkg.sv]
package lss_pkg;

   // Internal timer clock rate in whole megahertz
   localparam int CLK_MHZ = 20;

   // Power-up dead time after logic power or wake from sleep
   localparam int PU_US = 40;
   localparam int PU_CYC = PU_US * CLK_MHZ;

   // Mode-select mid level must persist strictly longer than this
   localparam int MODE_US = 10;
   localparam int MODE_CYC = MODE_US * CLK_MHZ + 1;

   // Fault qualification time, plain default
   localparam int TSS_US = 25;
   localparam int TSS_CYC = TSS_US * CLK_MHZ;

   // Refresh (off) time after a current-limit fault, plain default
   localparam int TREF_US = 1000;
   localparam int TREF_CYC = TREF_US * CLK_MHZ;

   // Output count and serial word size
   localparam int NUM_OUT = 6;
   localparam int WORD_BITS = 8;

   // Command word fields
   localparam int SLEEP_BIT = 7;
   localparam logic [7:0] CMD_RESET = 8'h00;

   // Status word fields: one fault flag per output in bits 5..0
   localparam int FAULT_LSB = 0;
   localparam logic [7:0] STATUS_RESET = 8'h00;

   // Output groups in dual mode and the output reset value
   localparam logic [5:0] GROUP0_MASK = 6'h31;
   localparam logic [5:0] GROUP1_MASK = 6'h0e;
   localparam logic [5:0] DRIVE_RESET = 6'h00;

   // Synchroniser idle value: chip select and enable high, rest low
   localparam int PIN_BITS = 19;
   localparam logic [18:0] PIN_IDLE = 19'h6_0000;

   // Power state of the control core
   typedef enum logic [1:0] {
      st_powerup,
      st_run,
      st_sleep
   } power_state_e;

endpackage

// [spi_low_side_switch_control_bench.sv]
`timescale 1ns/1ps
module spi_low_side_switch_control_bench;
   logic        clk_in, reset_in, en_n_in;   // Clock, reset, enable
   logic        p0, p1, p2, mode_mid_in;     // Parallel and mode pins
   logic        supply_sense_in;             // Overvoltage indication
   logic [5:0]  cur_limit_in, open_load_in;  // Fault conditions
   wire         sclk, cs_n, si, so, so_oe;   // Link pins
   wire         dual, sleep, rx_valid;       // Status outputs
   wire  [5:0]  drv;                         // Output gates
   wire  [15:0] rx;                          // Word read back
   logic        drv_look;                    // Strobe for drive checks
   logic [15:0] exp_rx[$];                   // Expected words
   logic [5:0]  exp_drv[$];                  // Expected drives
   logic [7:0]  cmd;                         // Current command
   int          fail_count = 0;              // Mismatches
   int          total_checks = 0;            // Comparisons

   // Design with a short refresh time
   lss_core #(.REFRESH_CYC(20)) lss_core_i (
      .clk_in(clk_in), .reset_in(reset_in), .sclk_in(sclk),
      .cs_n_in(cs_n), .si_in(si), .so_out(so), .so_oe_out(so_oe),
      .en_n_in(en_n_in), .par_in_0(p0), .par_in_1(p1),
      .par_in_mode_sel(p2), .mode_mid_in(mode_mid_in),
      .supply_sense_in(supply_sense_in), .cur_limit_in(cur_limit_in),
      .open_load_in(open_load_in), .drive_out_0(drv[0]),
      .drive_out_1(drv[1]), .drive_out_2(drv[2]), .drive_out_3(drv[3]),
      .drive_out_4(drv[4]), .drive_out_5(drv[5]),
      .dual_mode_out(dual), .sleep_out(sleep));

   // Far-side master
   spi_master_model spi_master_model_i (
      .sclk_out(sclk), .cs_n_out(cs_n), .si_out(si), .so_in(so),
      .so_oe_in(so_oe), .rx_out(rx), .rx_valid_out(rx_valid));

   // Main clock, 50 ns
   initial begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end

   // Prints the counts and the verdict, then stops
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // Compare a read-back word
   task automatic cmp_rx(input logic [15:0] e);
      total_checks++;
      if (rx !== e) begin
         fail_count++;
         $display("mismatch %0t read %h exp %h", $time, rx, e);
      end
   endtask

   // Compare the output gates
   task automatic cmp_drv(input logic [5:0] e);
      total_checks++;
      if (drv !== e) begin
         fail_count++;
         $display("mismatch %0t drives %h exp %h", $time, drv, e);
      end
   endtask

   // Compare a status flag
   task automatic cmp_bit(input logic v, input logic e);
      total_checks++;
      if (v !== e) begin
         fail_count++;
         $display("mismatch %0t flag %b exp %b", $time, v, e);
      end
   endtask

   // Monitors take the oldest note when a result appears
   always @(negedge rx_valid) cmp_rx(exp_rx.pop_front());
   always @(posedge drv_look) cmp_drv(exp_drv.pop_front());

   // Wait n falling edges
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_in);
   endtask

   // Note an expected drive value and look now
   task automatic expect_drv(input logic [5:0] e);
      exp_drv.push_back(e);
      drv_look = 1'b1;
      #1 drv_look = 1'b0;
   endtask

   // One 8-bit frame: new command, expected status back
   task automatic xfer(input logic [7:0] c, input logic [7:0] st);
      cmd = c;
      exp_rx.push_back({8'h00, st});
      spi_master_model_i.frame({8'h00, c}, 8);
      cmp_bit(so_oe, 1'b0);
      cyc(6);
   endtask

   // Hex mode drives
   function automatic logic [5:0] hexd(input logic [7:0] c);
      return c[5:0] | {3'b000, p2, p1, p0};
   endfunction

   // Dual mode drives
   function automatic logic [5:0] duald(input logic [7:0] c);
      logic g0, g1;
      g0 = p0 | (c[0] & c[4] & c[5]);
      g1 = p1 | (&c[3:1]);
      return {g0, g0, g1, g1, g1, g0};
   endfunction

   // Bounded wait for sleep (sel high) or dual mode; a miss ends the run
   task automatic wait_flag(input logic sel, input int lim);
      int k;
      for (k = 0; k < lim && (sel ? sleep : dual) !== 1'b1; k++) cyc(1);
      if (k == lim) begin
         fail_count++;
         $display("mismatch %0t wait ran out", $time);
         give_verdict();
      end
   endtask

   // Main sequence
   initial begin
      {reset_in, en_n_in, p0, p1, p2, mode_mid_in} = 6'h20;
      {supply_sense_in, cur_limit_in, open_load_in, drv_look} = 14'h0000;
      cmd = 8'h00;
      void'($urandom(45865));
      cyc(16);
      reset_in = 1'b0;
      cyc(20);
      expect_drv(6'h00); // Dead time after power-up
      cyc(800);
      // Random hex commands with random parallel inputs
      repeat (6) begin
         {p2, p1, p0} = 3'($urandom);
         xfer(8'($urandom) & 8'h3f, 8'h00);
         expect_drv(hexd(cmd));
      end
      $display("test hex done");
      // Two-byte frame: first byte comes back after the status
      {p2, p1, p0} = 3'b000;
      exp_rx.push_back({8'h00, 8'h5a});
      spi_master_model_i.frame({8'h5a, 8'h02}, 16);
      cyc(6);
      expect_drv(6'h02); // Last eight bits form the command
      $display("test chain done");
      // Current limit on 0 and open load on 3
      xfer(8'h01, 8'h00);
      {cur_limit_in, open_load_in} = {6'h01, 6'h08};
      cyc(520);
      {cur_limit_in, open_load_in} = 12'h000;
      cyc(40);
      xfer(8'h01, 8'h09);
      xfer(8'h01, 8'h00); // Cleared at frame end
      $display("test fault done");
      // Overvoltage gating
      xfer(8'h3f, 8'h00);
      supply_sense_in = 1'b1;
      cyc(5);
      expect_drv(6'h00);
      supply_sense_in = 1'b0;
      cyc(5);
      expect_drv(6'h3f);
      $display("test overvoltage done");
      // Dual mode qualification and group control
      mode_mid_in = 1'b1;
      cyc(150);
      cmp_bit(dual, 1'b0); // Too short to qualify
      wait_flag(1'b0, 200);
      for (int i = 0; i < 4; i++) begin
         {p1, p0} = 2'($urandom);
         xfer(i[1] ? (i[0] ? 8'h30 : 8'h06) : (i[0] ? 8'h0e : 8'h31),
              8'h00);
         expect_drv(duald(cmd));
      end
      mode_mid_in = 1'b0;
      {p1, p0} = 2'b01;
      cyc(5);
      cmp_bit(dual, 1'b0); // Back to hex
      $display("test dual done");
      // Enable high without sleep bit, then fall: no dead time
      xfer(8'h00, 8'h00);
      en_n_in = 1'b1;
      cyc(10);
      cmp_bit(sleep, 1'b0);
      en_n_in = 1'b0;
      cyc(5);
      expect_drv(6'h01);
      // Sleep, then wake with the dead time
      xfer(8'h82, 8'h00);
      en_n_in = 1'b1;
      wait_flag(1'b1, 20);
      expect_drv(6'h00);
      en_n_in = 1'b0;
      cyc(20);
      expect_drv(6'h00);
      cyc(800);
      expect_drv(6'h01); // Command zeroed in sleep
      xfer(8'h00, 8'h00);
      $display("test sleep done");
      cyc(10);
      give_verdict();
   end
endmodule // spi_low_side_switch_control_bench

// [spi_master_model.sv]
`timescale 1ns/1ps
// Behavioural serial master; link clock of 30 ns, idle low
module spi_master_model (
   output logic        sclk_out,     // Link clock, still between frames
   output logic        cs_n_out,     // Chip select, low active
   output logic        si_out,       // Data to the device
   input  wire logic   so_in,        // Data from the device
   input  wire logic   so_oe_in,     // Device drives its output
   output logic [15:0] rx_out,       // Word shifted back
   output logic        rx_valid_out  // Pulse at end of frame
);
   logic so_last;                    // Last level seen on the pin
   // Floating pin shows the inverse of its last level
   wire  so_line = so_oe_in ? so_in : ~so_last;
   // Idle levels at time zero
   initial begin
      sclk_out = 1'b0;
      cs_n_out = 1'b1;
      si_out = 1'b0;
      rx_out = 16'h0000;
      rx_valid_out = 1'b0;
      so_last = 1'b0;
   end
   // One frame of n bits, most significant first
   task automatic frame(input logic [15:0] tx, input int n);
      logic [15:0] rx;
      rx = 16'h0000;
      cs_n_out = 1'b0;
      #200; // Setup before the first rise
      for (int i = n - 1; i >= 0; i--) begin
         si_out = tx[i]; // Bit ahead of the rise
         #15 sclk_out = 1'b1;
         rx = {rx[14:0], so_line};
         so_last = so_line;
         #15 sclk_out = 1'b0;
      end
      #15 cs_n_out = 1'b1;
      si_out = ~si_out; // Released line does not hold its value
      rx_out = rx;
      rx_valid_out = 1'b1;
      #1 rx_valid_out = 1'b0;
      #200; // Deselect time between frames
   endtask
endmodule // spi_master_model
